// file: sdl_consts.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * segmented value logger.
 * Assumes it is included by bare name before any use of its macros.
 */
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SDL_CTRL_OFS      12'h000
`define SDL_CHEN_OFS      12'h004
`define SDL_STAT_OFS      12'h008
`define SDL_RDADDR_OFS    12'h00c
`define SDL_RDDATA_OFS    12'h010
`define SDL_TRIG_OFS      12'h014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SDL_CTRL_CONT_BIT 0
`define SDL_CTRL_ORG_LSB  1
`define SDL_CTRL_RATE_LSB 4
`define SDL_CTRL_PCT_LSB  8
`define SDL_CTRL_TEN_LSB  16
`define SDL_RDADDR_CH_LSB 12
`define SDL_RDADDR_BUF_LSB 16

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define SDL_CTRL_RST      32'h00051906
`define SDL_CHEN_RST      8'hff
`define SDL_LOG_DEPTH     13'h1000
`define SDL_PCT_MAX       7'h64
`define SDL_NUM_CH        8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SDL_CLK_NS        8
`define SDL_SEC_NS        1000000000
`define SDL_SEC_PER_MIN   60

`endif

// file: sdl_logger.sv
/*
 * Segmented value logger core: sample tick, continuous and triggered capture,
 * trigger position records and the APB register slave.
 * Assumes samples and event pulses come from logic on clk, and that the APB
 * master follows the usual setup/access sequence.
 */
// Function
// - Sample up to eight channels every tick.
// - Continuous: 4096-entry ring, oldest overwritten.
// - Trigger mode keeps records in own buffers.
// - Pre-collect, post-fill, then next buffer.
// - Full ring: new trigger overwrites oldest.
// - Setting change clears the whole log.
// - Interval: cycle, second, or minute choices.
// - One bit selects continuous or triggered.
// - Partition 2x2048 up to 16x256.
// - One buffer always reserved for next trigger.
// - Pre-trigger share 0 to 100 percent.
// - Zero starts at trigger; 100 pre only.
// - Early trigger: remainder filled post-trigger.
// - Trigger position recorded per buffer, readable.
// - Pickup triggers only when enabled.
// - Dropout triggers only when enabled.
// - Trip, alarm, control each separately enabled.
// - No channels enabled: no sampling, no triggers.
`include "sdl_consts.svh"
`default_nettype none

module sdl_logger #(
  parameter int DW          = 16,
  parameter int CLK_PER_SEC = `SDL_SEC_NS / `SDL_CLK_NS
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Measured values and events
  input  wire logic                     line_cycle,
  input  wire logic [`SDL_NUM_CH*DW-1:0] sample_vals,
  input  wire logic                     evt_pickup,
  input  wire logic                     evt_dropout,
  input  wire logic                     evt_trip,
  input  wire logic                     evt_trip_with_reclose,
  input  wire logic                     evt_alarm,
  input  wire logic                     evt_control
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Seconds per interval for the minute choices.
  function automatic logic [11:0] secs_of(input logic [3:0] rate);
    case (rate)
      4'h2:    secs_of = 12'(`SDL_SEC_PER_MIN);
      4'h3:    secs_of = 12'(5 * `SDL_SEC_PER_MIN);
      4'h4:    secs_of = 12'(10 * `SDL_SEC_PER_MIN);
      4'h5:    secs_of = 12'(15 * `SDL_SEC_PER_MIN);
      4'h6:    secs_of = 12'(20 * `SDL_SEC_PER_MIN);
      4'h7:    secs_of = 12'(30 * `SDL_SEC_PER_MIN);
      default: secs_of = 12'(60 * `SDL_SEC_PER_MIN);
    endcase
  endfunction

  // Closes the active buffer and makes the next one the reserved capture buffer.
  function automatic sdl_pkg::sdl_core_t close_buf(input sdl_pkg::sdl_core_t s,
                                                   input logic [4:0] nb);
    close_buf = s;
    close_buf.rvalid[s.bufi] = 1'b1;
    close_buf.bufi = (5'(s.bufi) + 5'h01 == nb) ? 4'h0 : s.bufi + 4'h1;
    close_buf.rvalid[close_buf.bufi] = 1'b0;
    close_buf.wptr = 12'h000;
    close_buf.filled = 13'h0000;
    close_buf.rem = 13'h0000;
    close_buf.st = sdl_pkg::SDL_ST_PRE;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  sdl_pkg::sdl_core_t r;
  sdl_pkg::sdl_core_t next_r;

  sdl_mem_if #(.DW(DW)) mif ();

  sdl_mem #(
    .DW    (DW),
    .DEPTH (`SDL_LOG_DEPTH)
  ) u_mem (
    .clk (clk),
    .mp  (mif.mem)
  );

  logic        cont;
  logic [1:0]  org;
  logic [3:0]  rate;
  logic [6:0]  pct;
  logic [4:0]  ten;
  logic [3:0]  sz_log;
  logic [12:0] bsize;
  logic [4:0]  nbuf;
  logic [12:0] pre_tgt;
  logic        chan_any;
  logic        sec_tick;
  logic        min_tick;
  logic        tick;
  logic        trig_raw;
  logic        trig_ok;
  logic        wr_acc;
  logic        clr;
  logic [11:0] buf_base;
  logic [31:0] rd_word;

  // --------------------------------------------------------------------------
  // Configuration decode
  // --------------------------------------------------------------------------
  always_comb begin
    cont     = r.ctrl[`SDL_CTRL_CONT_BIT];
    org      = r.ctrl[`SDL_CTRL_ORG_LSB +: 2];
    rate     = r.ctrl[`SDL_CTRL_RATE_LSB +: 4];
    pct      = r.ctrl[`SDL_CTRL_PCT_LSB +: 7];
    ten      = r.ctrl[`SDL_CTRL_TEN_LSB +: 5];
    sz_log   = 4'(4'hb - 4'(org));
    bsize    = 13'h0001 << sz_log;
    nbuf     = 5'h02 << org;
    pre_tgt  = 13'((20'(bsize) * 20'(pct)) / 20'(`SDL_PCT_MAX));
    chan_any = |r.chen;
    buf_base = 12'(12'(r.bufi) << sz_log);
  end

  // --------------------------------------------------------------------------
  // Sample tick and trigger
  // --------------------------------------------------------------------------
  assign sec_tick = (r.sec_cnt == 32'(CLK_PER_SEC - 1));
  // Greater-or-equal lets a count left high by a longer interval restart at once.
  assign min_tick = sec_tick && (r.min_cnt >= secs_of(rate) - 12'h001);
  assign tick     = (rate == 4'h0) ? line_cycle :
                    (rate == 4'h1) ? sec_tick : min_tick;
  assign trig_raw = (evt_pickup & ten[0])
                  | (evt_dropout & ten[1])
                  | ((evt_trip | evt_trip_with_reclose) & ten[2])
                  | (evt_alarm & ten[3])
                  | (evt_control & ten[4]);
  assign trig_ok  = trig_raw && !cont && chan_any;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign wr_acc = psel && penable && pwrite;
  assign clr    = wr_acc && (((paddr == `SDL_CTRL_OFS) && (pwdata != r.ctrl)) ||
                             ((paddr == `SDL_CHEN_OFS) && (pwdata[7:0] != r.chen)));

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `SDL_CTRL_OFS:   rd_word = r.ctrl;
      `SDL_CHEN_OFS:   rd_word = {24'h000000, r.chen};
      `SDL_STAT_OFS:   rd_word = {3'h0, r.st == sdl_pkg::SDL_ST_POST, 3'h0,
                                  5'($countones(r.rvalid)), r.bufi, 3'h0, r.cnt};
      `SDL_RDADDR_OFS: rd_word = {12'h000, r.rdaddr};
      `SDL_RDDATA_OFS: rd_word = 32'(mif.rd_data[r.rdaddr[`SDL_RDADDR_CH_LSB +: 3]*DW +: DW]);
      `SDL_TRIG_OFS:   rd_word = {r.rvalid[r.rdaddr[`SDL_RDADDR_BUF_LSB +: 4]], 2'h0,
                                  r.trig_pre[r.rdaddr[`SDL_RDADDR_BUF_LSB +: 4]], 4'h0,
                                  r.trig_off[r.rdaddr[`SDL_RDADDR_BUF_LSB +: 4]]};
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    mif.wr_en   = 1'b0;
    mif.wr_addr = 12'h000;
    mif.rd_en   = 1'b0;
    mif.rd_addr = pwdata[11:0];
    for (int c = 0; c < `SDL_NUM_CH; c++) begin
      mif.wr_data[c*DW +: DW] = r.chen[c] ? sample_vals[c*DW +: DW] : '0;
    end

    next_r.sec_cnt = sec_tick ? 32'h0000_0000 : r.sec_cnt + 32'h0000_0001;
    if (sec_tick) begin
      next_r.min_cnt = min_tick ? 12'h000 : r.min_cnt + 12'h001;
    end

    if (cont) begin
      if (tick && chan_any) begin
        mif.wr_en      = 1'b1;
        mif.wr_addr    = r.wptr;
        next_r.wptr    = r.wptr + 12'h001;
        next_r.cnt     = (r.cnt == `SDL_LOG_DEPTH) ? r.cnt : r.cnt + 13'h0001;
      end
    end else begin
      case (r.st)
        sdl_pkg::SDL_ST_PRE: begin
          // Pre samples roll round the whole buffer; only pre_tgt are counted.
          if (tick && chan_any && (pre_tgt != 13'h0000)) begin
            mif.wr_en     = 1'b1;
            mif.wr_addr   = buf_base | r.wptr;
            next_r.wptr   = (13'(r.wptr) + 13'h0001 == bsize) ? 12'h000 : r.wptr + 12'h001;
            next_r.filled = (r.filled >= pre_tgt) ? pre_tgt : r.filled + 13'h0001;
          end
          if (trig_ok) begin
            next_r.trig_off[r.bufi] = next_r.wptr;
            next_r.trig_pre[r.bufi] = next_r.filled;
            next_r.rem = bsize - next_r.filled;
            if (next_r.rem == 13'h0000) begin
              next_r = close_buf(next_r, nbuf);
            end else begin
              next_r.st = sdl_pkg::SDL_ST_POST;
            end
          end
        end
        sdl_pkg::SDL_ST_POST: begin
          if (tick && chan_any) begin
            mif.wr_en   = 1'b1;
            mif.wr_addr = buf_base | r.wptr;
            next_r.wptr = (13'(r.wptr) + 13'h0001 == bsize) ? 12'h000 : r.wptr + 12'h001;
            next_r.rem  = r.rem - 13'h0001;
            if (r.rem == 13'h0001) begin
              next_r = close_buf(next_r, nbuf);
            end
          end
        end
        default: begin
          next_r.st = sdl_pkg::SDL_ST_PRE;
        end
      endcase
    end

    if (wr_acc) begin
      case (paddr)
        `SDL_CTRL_OFS: begin
          next_r.ctrl = pwdata;
          if (pwdata[`SDL_CTRL_PCT_LSB +: 7] > `SDL_PCT_MAX) begin
            next_r.ctrl[`SDL_CTRL_PCT_LSB +: 7] = `SDL_PCT_MAX;
          end
        end
        `SDL_CHEN_OFS: next_r.chen = pwdata[7:0];
        `SDL_RDADDR_OFS: begin
          next_r.rdaddr = pwdata[19:0];
          mif.rd_en     = 1'b1;
        end
        default: next_r.pslverr = r.pslverr;
      endcase
    end

    // A setting change empties the log; stale rows stay unread behind zero counts.
    if (clr) begin
      next_r.cnt    = 13'h0000;
      next_r.wptr   = 12'h000;
      next_r.filled = 13'h0000;
      next_r.rem    = 13'h0000;
      next_r.bufi   = 4'h0;
      next_r.rvalid = 16'h0000;
      next_r.st     = sdl_pkg::SDL_ST_PRE;
    end

    if (psel && !penable) begin
      next_r.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      next_r.pslverr = (paddr > `SDL_TRIG_OFS) || (paddr[1:0] != 2'b00);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '{ctrl: `SDL_CTRL_RST, chen: `SDL_CHEN_RST, st: sdl_pkg::SDL_ST_PRE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = 1'b1;
  assign pslverr = r.pslverr && psel && penable;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_sample_on_tick;
    mif.wr_en |-> tick && chan_any;
  endproperty
  a_sample_on_tick: assert property (p_sample_on_tick) else $error("store written without a tick");

  property p_ring_wrap;
    cont && tick && chan_any && !clr |=> r.wptr == 12'($past(r.wptr) + 12'h001) && r.cnt <= `SDL_LOG_DEPTH;
  endproperty
  a_ring_wrap: assert property (p_ring_wrap) else $error("continuous pointer did not advance");

  property p_clear;
    clr |=> r.cnt == 13'h0000 && r.rvalid == 16'h0000 && r.filled == 13'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("setting change did not clear the log");

  property p_reserved;
    $countones(r.rvalid) <= 32'(nbuf) - 1 && !r.rvalid[r.bufi];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved buffer holds a record");

  property p_no_channels;
    !chan_any |-> !mif.wr_en ##1 $stable(r.rvalid) || $past(clr);
  endproperty
  a_no_channels: assert property (p_no_channels) else $error("activity with all channels off");

  property p_cont_ignores;
    cont && !clr |=> r.st == $past(r.st) && r.rvalid == $past(r.rvalid);
  endproperty
  a_cont_ignores: assert property (p_cont_ignores) else $error("trigger acted in continuous mode");

  property p_post_len;
    r.st == sdl_pkg::SDL_ST_PRE && trig_ok && !clr && next_r.st == sdl_pkg::SDL_ST_POST
      |=> r.rem == bsize - r.trig_pre[r.bufi] && r.trig_pre[r.bufi] <= pre_tgt;
  endproperty
  a_post_len: assert property (p_post_len) else $error("post count wrong after trigger");

  property p_full_pre;
    r.st == sdl_pkg::SDL_ST_PRE && trig_ok && !clr && !tick && r.filled == bsize
      |=> r.st == sdl_pkg::SDL_ST_PRE && r.rvalid[$past(r.bufi)];
  endproperty
  a_full_pre: assert property (p_full_pre) else $error("full pre buffer not closed at trigger");

  property p_trig_pos;
    r.st == sdl_pkg::SDL_ST_PRE && trig_ok && !clr && !tick
      |=> r.trig_off[$past(r.bufi)] == $past(r.wptr) && r.trig_pre[$past(r.bufi)] == $past(r.filled);
  endproperty
  a_trig_pos: assert property (p_trig_pos) else $error("trigger position not recorded");

endmodule

`default_nettype wire

// file: sdl_mem.sv
/*
 * Sample store: one row of all channels per address, registered read.
 * Assumes the core never needs the read data in the cycle of the request.
 */
`include "sdl_consts.svh"
`default_nettype none

module sdl_mem #(
  parameter int DW    = 16,
  parameter int DEPTH = 4096
) (
  // Clock
  input wire logic clk,
  // Store port
  sdl_mem_if.mem   mp
);

  logic [`SDL_NUM_CH*DW-1:0] store [DEPTH];
  logic [`SDL_NUM_CH*DW-1:0] rd_q;

  // The array itself has no reset; an empty log is shown by the core's counts.
  always_ff @(posedge clk) begin
    if (mp.wr_en) begin
      store[mp.wr_addr] <= mp.wr_data;
    end
    if (mp.rd_en) begin
      rd_q <= store[mp.rd_addr];
    end
  end

  assign mp.rd_data = rd_q;

endmodule

`default_nettype wire

// file: sdl_mem_if.sv
/*
 * Carrier between the logger core and its sample store.
 * Assumes one clock shared by both ends.
 */
`include "sdl_consts.svh"
`default_nettype none

interface sdl_mem_if #(
  parameter int DW = 16
);
  logic                     wr_en;
  logic [11:0]              wr_addr;
  logic [`SDL_NUM_CH*DW-1:0] wr_data;
  logic                     rd_en;
  logic [11:0]              rd_addr;
  logic [`SDL_NUM_CH*DW-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// file: sdl_pkg.sv
/*
 * Types shared by the segmented value logger modules.
 * Assumes sdl_consts.svh holds the numeric constants.
 */
`default_nettype none

package sdl_pkg;

  // --------------------------------------------------------------------------
  // Trigger-mode capture states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDL_ST_PRE  = 2'b01,
    SDL_ST_POST = 2'b10
  } sdl_state_e_t;

  // --------------------------------------------------------------------------
  // Whole state of the logger core
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]       ctrl;
    logic [7:0]        chen;
    logic [19:0]       rdaddr;
    logic [12:0]       cnt;
    logic [11:0]       wptr;
    logic [12:0]       filled;
    logic [12:0]       rem;
    logic [3:0]        bufi;
    sdl_state_e_t      st;
    logic [15:0][11:0] trig_off;
    logic [15:0][12:0] trig_pre;
    logic [15:0]       rvalid;
    logic [31:0]       sec_cnt;
    logic [11:0]       min_cnt;
    logic [31:0]       prdata;
    logic              pslverr;
  } sdl_core_t;

endpackage

`default_nettype wire

// file: sdl_src_model.sv
/*
 * Model of the metering and protection logic that feeds the logger.
 * Assumes the bench asks for bursts of sample ticks and for event pulses.
 */
`include "sdl_consts.svh"
`default_nettype none

module sdl_src_model #(
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Bench requests
  input  wire logic                       go,
  input  wire logic [15:0]                n_ticks,
  input  wire logic [5:0]                 evt_req,
  output logic                            busy,
  // Logger side
  output logic                            line_cycle,
  output logic      [`SDL_NUM_CH*DW-1:0]  sample_vals,
  output logic      [5:0]                 evts
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] left;
  logic        ph;
  logic [12:0] k;

  // Ticks come every other cycle, so a logger that samples twice per pulse is caught.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      left <= 16'h0000;
      ph <= 1'b0;
      k <= 13'h0000;
      line_cycle <= 1'b0;
      evts <= 6'h00;
    end else begin
      evts <= evt_req;
      line_cycle <= 1'b0;
      if (line_cycle) begin
        k <= k + 13'h0001;
      end
      if (go) begin
        left <= n_ticks;
        ph <= 1'b0;
      end else if (left != 16'h0000) begin
        ph <= ~ph;
        if (ph) begin
          line_cycle <= 1'b1;
          left <= left - 16'h0001;
        end
      end
    end
  end

  // Each value carries its channel in the top bits and the sample index below.
  always_comb begin
    for (int c = 0; c < `SDL_NUM_CH; c++) begin
      sample_vals[c*DW +: DW] = DW'({c[2:0], k});
    end
  end

  assign busy = (left != 16'h0000) || line_cycle;
endmodule

`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench of the segmented value logger over APB.
 * Assumes sdl_src_model feeds samples and events on the same clock.
 */
`include "sdl_consts.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        go = 1'b0;
  logic [15:0] n_ticks = 16'h0000;
  logic [5:0]  evt_req = 6'h00;
  logic [5:0]  evts;
  logic        busy;
  logic        line_cycle;
  logic [127:0] sample_vals;
  logic [31:0] q;
  logic        e;
  int          failures = 0;
  int          compares = 0;

  always #4 clk = ~clk;

  sdl_logger #(.DW(16), .CLK_PER_SEC(10)) dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_cycle(line_cycle), .sample_vals(sample_vals), .evt_pickup(evts[0]),
    .evt_dropout(evts[1]), .evt_trip(evts[2]), .evt_trip_with_reclose(evts[3]),
    .evt_alarm(evts[4]), .evt_control(evts[5]));

  sdl_src_model #(.DW(16)) src (
    .clk(clk), .reset(reset), .go(go), .n_ticks(n_ticks), .evt_req(evt_req),
    .busy(busy), .line_cycle(line_cycle), .sample_vals(sample_vals), .evts(evts));

  // --------------------------------------------------------------------------
  // Bus and stimulus tasks
  // --------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    go <= 1'b1;
    n_ticks <= 16'(n);
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
    end while (busy !== 1'b0);
  endtask

  task automatic fire(input logic [5:0] m);
    evt_req <= m;
    @(posedge clk);
    evt_req <= 6'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic row(input logic [11:0] r, input logic [2:0] c);
    apb(1'b1, `SDL_RDADDR_OFS, {17'h00000, c, r});
    apb(1'b0, `SDL_RDDATA_OFS, 32'h00000000);
  endtask

  function automatic logic [31:0] ctl(logic c, logic [1:0] o, logic [3:0] r, logic [6:0] p, logic [4:0] en);
    return {11'h000, en, 1'b0, p, r, 1'b0, o, c};
  endfunction

  task automatic results();
    $display("checks %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  int pct[3] = '{33, 50, 100};
  int pre[3] = '{100, 10, 300};
  int held[3] = '{84, 10, 256};

  initial begin
    #(64'd60000 * 8);
    failures++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, `SDL_CTRL_OFS, 32'h0);
    chk("ctrl_rst", `SDL_CTRL_RST, q);
    apb(1'b0, `SDL_CHEN_OFS, 32'h0);
    chk("chen_rst", {24'h0, `SDL_CHEN_RST}, q);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", 32'h00000001, {q[30:0], e});
    apb(1'b1, `SDL_CTRL_OFS, ctl(1'b1, 2'h3, 4'h0, 7'h00, 5'h1f));
    ticks(4100);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("cont_count", 32'h1000, {19'h0, q[12:0]});
    row(12'h000, 3'h3);
    chk("cont_row0", 32'h7000, q);
    row(12'h004, 3'h3);
    chk("cont_row4", 32'h6004, q);
    fire(6'h3f);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("cont_no_trig", 32'h0, {31'h0, q[28]});
    apb(1'b1, `SDL_CHEN_OFS, 32'h000000f7);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("clear", 32'h0, {19'h0, q[12:0]});
    ticks(3);
    row(12'h001, 3'h3);
    chk("chan_off", 32'h0, q);
    row(12'h001, 3'h2);
    chk("chan_on", 32'h5005, q);
    apb(1'b1, `SDL_CHEN_OFS, 32'h0);
    apb(1'b1, `SDL_CTRL_OFS, ctl(1'b0, 2'h3, 4'h0, 7'h00, 5'h1f));
    fire(6'h3f);
    ticks(2);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("chen_zero", 32'h0, {31'h0, q[28]});
    apb(1'b1, `SDL_CHEN_OFS, 32'h000000ff);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `SDL_CTRL_OFS, ctl(1'b0, 2'h3, 4'h0, 7'h00, ~(5'h01 << (i < 3 ? i : i - 1))));
      fire(6'h01 << i);
      apb(1'b0, `SDL_STAT_OFS, 32'h0);
      chk("evt_masked", 32'h0, {31'h0, q[28]});
      apb(1'b1, `SDL_CTRL_OFS, ctl(1'b0, 2'h3, 4'h0, 7'h00, 5'h01 << (i < 3 ? i : i - 1)));
      fire(6'h01 << i);
      apb(1'b0, `SDL_STAT_OFS, 32'h0);
      chk("evt_enabled", 32'h1, {31'h0, q[28]});
    end
    apb(1'b1, `SDL_CTRL_OFS, ctl(1'b0, 2'h3, 4'h0, 7'h00, 5'h01));
    for (int j = 0; j < 17; j++) begin
      fire(6'h01);
      ticks(256);
      apb(1'b0, `SDL_STAT_OFS, 32'h0);
      chk("records", (j < 15) ? j + 1 : 15, {27'h0, q[24:20]});
      chk("active_buf", (j + 1) % 16, {27'h0, q[28], q[19:16]});
    end
    apb(1'b0, `SDL_TRIG_OFS, 32'h0);
    chk("buf0_reused", 32'h1, {31'h0, q[31]});
    apb(1'b1, `SDL_RDADDR_OFS, 32'h00010000);
    apb(1'b0, `SDL_TRIG_OFS, 32'h0);
    chk("buf1_reserved", 32'h0, {31'h0, q[31]});
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, `SDL_CTRL_OFS, ctl(1'b0, 2'h3, 4'h0, 7'(pct[p]), 5'h01));
      ticks(pre[p]);
      fire(6'h01);
      ticks(256 - held[p]);
      apb(1'b0, `SDL_STAT_OFS, 32'h0);
      chk("pre_closed", 32'h11, {27'h0, q[24:20]} << 4 | q[19:16]);
      apb(1'b1, `SDL_RDADDR_OFS, 32'h0);
      apb(1'b0, `SDL_TRIG_OFS, 32'h0);
      chk("pre_held", 32'h80000000 | (held[p] << 16) | (pre[p] % 256), q & 32'h9fff0fff);
    end
    apb(1'b1, `SDL_CTRL_OFS, ctl(1'b0, 2'h2, 4'h0, 7'h00, 5'h01));
    fire(6'h01);
    ticks(511);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("org_open", 32'h200, {22'h0, q[28], q[24:20], q[19:16]});
    ticks(1);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("org_closed", 32'h011, {22'h0, q[28], q[24:20], q[19:16]});
    apb(1'b1, `SDL_CTRL_OFS, ctl(1'b1, 2'h0, 4'h1, 7'h00, 5'h1f));
    repeat (100) @(posedge clk);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("rate_sec", 32'h1, {31'h0, q[12:0] >= 9 && q[12:0] <= 11});
    apb(1'b1, `SDL_CTRL_OFS, ctl(1'b1, 2'h0, 4'h2, 7'h00, 5'h1f));
    repeat (1250) @(posedge clk);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("rate_min", 32'h1, {31'h0, q[12:0] >= 1 && q[12:0] <= 3});
    apb(1'b1, `SDL_CTRL_OFS, ctl(1'b1, 2'h0, 4'h3, 7'h00, 5'h1f));
    repeat (3100) @(posedge clk);
    apb(1'b0, `SDL_STAT_OFS, 32'h0);
    chk("rate_5min", 32'h1, {31'h0, q[12:0] >= 1 && q[12:0] <= 2});
    results();
  end
endmodule

`default_nettype wire
